// File: src/aesc_consts.vh
// Constants for the register-driven block cipher core
// Contract
// R1: Three-bit select picks encrypt/decrypt and key size
// R2: Software avoids select codes three and seven
// R3: Eight writable 32-bit key words form store
// R4: 128-bit key uses key words zero to three
// R5: 192-bit key uses key words zero to five
// R6: 256-bit key uses all eight key words
// R7: Four 32-bit text words hold in/out block
// R8: Encryption overwrites plaintext words with ciphertext
// R9: Decryption overwrites ciphertext words with plaintext
// R10: Order bits one:zero arrange key bytes
// R11: Order bits three:two input, five:four output
// R12: Input/output text roles follow cipher direction
// R13: Text bytes form state per order setting
// R14: Default order: column c from word three-c
`ifndef AESC_CONSTS_VH
`define AESC_CONSTS_VH

`define AESC_ADDR_MODE   8'h00
`define AESC_ADDR_START  8'h04
`define AESC_ADDR_IDLE   8'h08
`define AESC_ADDR_ORDER  8'h0C
`define AESC_ADDR_KEY0   8'h10
`define AESC_ADDR_KEY7   8'h2C
`define AESC_ADDR_TEXT0  8'h30
`define AESC_ADDR_TEXT3  8'h3C

`define AESC_MODE_DEC    2
`define AESC_MODE_RSVD   2'h3
`define AESC_ORD_KEY     1:0
`define AESC_ORD_IN      3:2
`define AESC_ORD_OUT     5:4

`define AESC_NK_BASE     4'h4
`define AESC_NR_BASE     4'hA
`define AESC_RCON0       8'h01
`define AESC_POLY        8'h1B
`define AESC_AFF         8'h63
`define AESC_IAFF        8'h05
`define AESC_MIX_E       32'h02030101
`define AESC_MIX_D       32'h0E0B0D09

`endif

// File: src/aesc_core.v
// Iterative block cipher core with register port and key expansion
//
// The plain strobed port and the address map are this design's own decisions.
`timescale 1ns/1ps
`include "aesc_consts.vh"

module aesc_core (
  input  wire        clk_i,
  input  wire        resetn_i,
  input  wire [7:0]  addr_i,
  input  wire [31:0] wdata_i,
  input  wire        wr_i,
  input  wire        rd_i,
  output reg  [31:0] rdata_o,
  output wire        idle_o
);

  localparam [4:0] ST_IDLE = 5'b00001;
  localparam [4:0] ST_KEXP = 5'b00010;
  localparam [4:0] ST_INIT = 5'b00100;
  localparam [4:0] ST_RUN  = 5'b01000;
  localparam [4:0] ST_WB   = 5'b10000;

  reg [4:0]   fsm_r;
  reg [2:0]   mode_r;
  reg [5:0]   order_r;
  reg [31:0]  key_r [0:7];
  reg [31:0]  text_r [0:3];
  reg [31:0]  kexp_r [0:59];
  reg [127:0] st_r;
  reg [5:0]   cnt_r;
  reg [2:0]   j_r;
  reg [7:0]   rcon_r;
  reg [3:0]   rnd_r;
  integer     k;

  // Multiply by x in the cipher field
  function [7:0] xt(input [7:0] a);
    xt = {a[6:0], 1'b0} ^ (a[7] ? `AESC_POLY : 8'h00);
  endfunction

  function [7:0] gm(input [7:0] a, input [7:0] b);
    integer i;
    reg [7:0] p, x;
    begin
      p = 8'h00;
      x = a;
      for (i = 0; i < 8; i = i + 1) begin
        if (b[i]) p = p ^ x;
        x = xt(x);
      end
      gm = p;
    end
  endfunction

  // Field inverse as a to the power 254
  function [7:0] ginv(input [7:0] a);
    integer i;
    reg [7:0] s, r;
    begin
      s = a;
      r = 8'h01;
      for (i = 1; i < 8; i = i + 1) begin
        s = gm(s, s);
        r = gm(r, s);
      end
      ginv = r;
    end
  endfunction

  function [7:0] sbox(input [7:0] a);
    reg [7:0] i;
    begin
      i = ginv(a);
      sbox = i ^ {i[6:0], i[7]} ^ {i[5:0], i[7:6]} ^ {i[4:0], i[7:5]}
             ^ {i[3:0], i[7:4]} ^ `AESC_AFF;
    end
  endfunction

  function [7:0] isbox(input [7:0] a);
    isbox = ginv({a[6:0], a[7]} ^ {a[4:0], a[7:5]} ^ {a[1:0], a[7:2]}
                 ^ `AESC_IAFF);
  endfunction

  function [31:0] subw(input [31:0] w);
    subw = {sbox(w[31:24]), sbox(w[23:16]), sbox(w[15:8]), sbox(w[7:0])};
  endfunction

  function [31:0] bsw(input [31:0] w);
    bsw = {w[7:0], w[15:8], w[23:16], w[31:24]};
  endfunction

  // Row shift and byte substitution, forward or inverse
  function [127:0] srsub(input [127:0] s, input inv);
    integer c, r, sc;
    begin
      srsub = 128'h0;
      for (c = 0; c < 4; c = c + 1) begin
        for (r = 0; r < 4; r = r + 1) begin
          sc = inv ? (c + 4 - r) % 4 : (c + r) % 4;
          srsub[127-8*(4*c+r) -: 8] = inv ?
            isbox(s[127-8*(4*sc+r) -: 8]) : sbox(s[127-8*(4*sc+r) -: 8]);
        end
      end
    end
  endfunction

  // Column mix with a circulant coefficient row
  function [127:0] mix(input [127:0] s, input [31:0] m);
    integer c, r, q;
    reg [7:0] acc;
    begin
      mix = 128'h0;
      for (c = 0; c < 4; c = c + 1) begin
        for (r = 0; r < 4; r = r + 1) begin
          acc = 8'h00;
          for (q = 0; q < 4; q = q + 1)
            acc = acc ^ gm(s[127-8*(4*c+(r+q)%4) -: 8], m[31-8*q -: 8]);
          mix[127-8*(4*c+r) -: 8] = acc;
        end
      end
    end
  endfunction

  wire       dec  = mode_r[`AESC_MODE_DEC];                   // see R1
  wire [3:0] nk   = `AESC_NK_BASE + {1'b0, mode_r[1:0], 1'b0}; // see R4
  wire [3:0] nr   = `AESC_NR_BASE + {1'b0, mode_r[1:0], 1'b0};
  wire [5:0] last = {nr, 2'b11};
  wire       bus_start = wr_i && (addr_i == `AESC_ADDR_START) && wdata_i[0];
  wire       mode_ok = (mode_r[1:0] != `AESC_MODE_RSVD);      // see R2

  // Key word feeding expansion, only the first nk words are taken
  wire [2:0] kidx = order_r[1] ? nk[2:0] - 3'h1 - cnt_r[2:0]  // see R10
                               : cnt_r[2:0];                  // see R5
  wire [31:0] kraw = order_r[0] ? bsw(key_r[kidx]) : key_r[kidx];
  wire [31:0] wprev = kexp_r[cnt_r - 6'h1];
  wire [31:0] wfar  = kexp_r[cnt_r - {2'b00, nk}];
  wire [31:0] rot = {wprev[23:0], wprev[31:24]};
  reg  [31:0] kw;

  always @* begin
    if (cnt_r < {2'b00, nk})
      kw = kraw;                                              // see R6
    else if (j_r == 3'h0)
      kw = wfar ^ subw(rot) ^ {rcon_r, 24'h000000};
    else if (nk == 4'h8 && j_r == 3'h4)
      kw = wfar ^ subw(wprev);
    else
      kw = wfar ^ wprev;
  end

  always @(posedge clk_i) begin
    if (fsm_r == ST_KEXP) kexp_r[cnt_r] <= kw;
  end

  // Round key select: encryption walks up, decryption walks down
  reg  [3:0]   rsel;
  wire [5:0]   rki = {rsel, 2'b00};
  wire [127:0] rk = {kexp_r[rki], kexp_r[rki + 6'h1],
                     kexp_r[rki + 6'h2], kexp_r[rki + 6'h3]};

  always @* begin
    if (fsm_r == ST_INIT)
      rsel = dec ? nr : 4'h0;
    else
      rsel = dec ? nr - rnd_r : rnd_r;
  end

  // Text words into the state array, input arrangement
  reg [127:0] tin;
  reg [1:0]   twi;
  integer     c;
  always @* begin
    tin = 128'h0;
    twi = 2'h0;
    for (c = 0; c < 4; c = c + 1) begin
      twi = order_r[3] ? c[1:0] : 2'h3 - c[1:0];              // see R14
      tin[127-32*c -: 32] = order_r[2] ? bsw(text_r[twi])     // see R13
                                       : text_r[twi];         // see R12
    end
  end

  // One round step on the state
  reg [127:0] step;
  always @* begin
    if (!dec) begin
      step = srsub(st_r, 1'b0);
      if (rnd_r != nr) step = mix(step, `AESC_MIX_E);
      step = step ^ rk;
    end else begin
      step = srsub(st_r, 1'b1) ^ rk;
      if (rnd_r != nr) step = mix(step, `AESC_MIX_D);
    end
  end

  assign idle_o = (fsm_r == ST_IDLE);

  always @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      fsm_r   <= ST_IDLE;
      mode_r  <= 3'h0;
      order_r <= 6'h00;
      st_r    <= 128'h0;
      cnt_r   <= 6'h00;
      j_r     <= 3'h0;
      rcon_r  <= `AESC_RCON0;
      rnd_r   <= 4'h0;
      rdata_o <= 32'h00000000;
      for (k = 0; k < 8; k = k + 1) key_r[k] <= 32'h00000000;
      for (k = 0; k < 4; k = k + 1) text_r[k] <= 32'h00000000;
    end else begin
      if (rd_i) begin
        if (addr_i == `AESC_ADDR_MODE)
          rdata_o <= {29'h0, mode_r};
        else if (addr_i == `AESC_ADDR_IDLE)
          rdata_o <= {31'h0, idle_o};
        else if (addr_i == `AESC_ADDR_ORDER)
          rdata_o <= {26'h0, order_r};
        else if (addr_i >= `AESC_ADDR_KEY0 && addr_i <= `AESC_ADDR_KEY7
                 && addr_i[1:0] == 2'h0)
          rdata_o <= key_r[addr_i[4:2] - 3'h4];
        else if (addr_i >= `AESC_ADDR_TEXT0 && addr_i <= `AESC_ADDR_TEXT3
                 && addr_i[1:0] == 2'h0)
          rdata_o <= text_r[addr_i[3:2]];
        else
          rdata_o <= 32'h00000000;
      end
      // Configuration writes only land while the engine is idle
      if (wr_i && idle_o) begin
        if (addr_i == `AESC_ADDR_MODE) mode_r <= wdata_i[2:0];   // see R1
        if (addr_i == `AESC_ADDR_ORDER) order_r <= wdata_i[5:0]; // see R11
        if (addr_i >= `AESC_ADDR_KEY0 && addr_i <= `AESC_ADDR_KEY7
            && addr_i[1:0] == 2'h0)
          key_r[addr_i[4:2] - 3'h4] <= wdata_i;                   // see R3
        if (addr_i >= `AESC_ADDR_TEXT0 && addr_i <= `AESC_ADDR_TEXT3
            && addr_i[1:0] == 2'h0)
          text_r[addr_i[3:2]] <= wdata_i;                         // see R7
      end
      case (fsm_r)
        ST_IDLE: begin
          if (bus_start && mode_ok) begin
            cnt_r  <= 6'h00;
            j_r    <= 3'h0;
            rcon_r <= `AESC_RCON0;
            fsm_r  <= ST_KEXP;
          end
        end
        ST_KEXP: begin
          cnt_r <= cnt_r + 6'h1;
          j_r   <= (j_r == nk[2:0] - 3'h1) ? 3'h0 : j_r + 3'h1;
          if (cnt_r >= {2'b00, nk} && j_r == 3'h0) rcon_r <= xt(rcon_r);
          if (cnt_r == last) fsm_r <= ST_INIT;
        end
        ST_INIT: begin
          st_r  <= tin ^ rk;
          rnd_r <= 4'h1;
          fsm_r <= ST_RUN;
        end
        ST_RUN: begin
          st_r  <= step;
          rnd_r <= rnd_r + 4'h1;
          if (rnd_r == nr) fsm_r <= ST_WB;
        end
        ST_WB: begin
          // Result replaces the input words, output arrangement
          for (k = 0; k < 4; k = k + 1) begin                   // see R8
            if (order_r[5])                                     // see R9
              text_r[k] <= order_r[4] ? bsw(st_r[127-32*k -: 32])
                                      : st_r[127-32*k -: 32];
            else
              text_r[3-k] <= order_r[4] ? bsw(st_r[127-32*k -: 32])
                                        : st_r[127-32*k -: 32];
          end
          fsm_r <= ST_IDLE;
        end
        default: fsm_r <= ST_IDLE;
      endcase
    end
  end

endmodule // aesc_core

// File: tb/aesc_core_properties.sv
// Port-level properties of the block cipher core
`timescale 1ns/1ps

module aesc_core_properties (
  input  wire logic        clk_i,
  input  wire logic        resetn_i,
  input  wire logic [7:0]  addr_i,
  input  wire logic [31:0] wdata_i,
  input  wire logic        wr_i,
  input  wire logic        rd_i,
  input  wire logic [31:0] rdata_o,
  input  wire logic        idle_o
);
  logic [2:0] mode_r;
  logic [7:0] cnt_r;
  logic       go;

  default clocking @(posedge clk_i); endclocking
  default disable iff (!resetn_i);

  assign go = wr_i && addr_i == 8'h04 && wdata_i[0] && idle_o;

  // Mode as last taken while idle, busy cycles counted
  always @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      mode_r <= 3'h0;
      cnt_r  <= 8'h00;
    end else begin
      if (wr_i && addr_i == 8'h00 && idle_o) begin
        mode_r <= wdata_i[2:0];
      end
      cnt_r <= idle_o ? 8'h00 : cnt_r + 8'h01;
    end
  end

  chk_start_busy: assert property (go && mode_r[1:0] != 2'h3 |=> !idle_o)
    else $error("start did not leave idle");
  chk_rsvd_idle: assert property (go && mode_r[1:0] == 2'h3 |=> idle_o ##1 idle_o)
    else $error("reserved mode started the engine");
  chk_busy_len: assert property ($rose(idle_o) |->
    cnt_r == 8'h38 + 8'h0A * {6'h00, mode_r[1:0]})
    else $error("busy span does not fit key size");
  chk_unmapped_zero: assert property (rd_i && addr_i >= 8'h40 |=> rdata_o == 32'h0)
    else $error("unmapped read not zero");
  chk_idle_read: assert property (rd_i && addr_i == 8'h08 |=>
    rdata_o == {31'h0, $past(idle_o)})
    else $error("idle read mismatch");
  chk_key_back: assert property (wr_i && addr_i == 8'h10 && idle_o ##1
    rd_i && addr_i == 8'h10 |=> rdata_o == $past(wdata_i, 2))
    else $error("key word readback mismatch");
  chk_text_back: assert property (wr_i && addr_i == 8'h30 && idle_o ##1
    rd_i && addr_i == 8'h30 |=> rdata_o == $past(wdata_i, 2))
    else $error("text word readback mismatch");
  chk_order_back: assert property (wr_i && addr_i == 8'h0C && idle_o ##1
    rd_i && addr_i == 8'h0C |=> rdata_o == ($past(wdata_i, 2) & 32'h3F))
    else $error("order readback mismatch");
  chk_mode_back: assert property (wr_i && addr_i == 8'h00 && idle_o ##1
    rd_i && addr_i == 8'h00 |=> rdata_o == ($past(wdata_i, 2) & 32'h7))
    else $error("mode readback mismatch");
endmodule // aesc_core_properties

bind aesc_core aesc_core_properties u_props (.clk_i(clk_i),
  .resetn_i(resetn_i), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i),
  .rd_i(rd_i), .rdata_o(rdata_o), .idle_o(idle_o));

// File: tb/test_aes_block_cipher_core.sv
// Self-checking bench for the block cipher core
`timescale 1ns/1ps
`define AESC_CHK(a, b) begin tests_run++; if ((a) !== (b)) begin fails++; \
  $display("[FAIL] t=%0t got %h exp %h", $time, a, b); end end

module test_aes_block_cipher_core;
  logic        clk_i, resetn_i, wr_i, rd_i, idle_o;
  logic [7:0]  addr_i;
  logic [31:0] wdata_i, rdata_o;
  int          fails, tests_run;

  aesc_core u_dut (.clk_i(clk_i), .resetn_i(resetn_i), .addr_i(addr_i),
    .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
    .idle_o(idle_o));

  initial begin
    clk_i = 1'b0;
    forever #4 clk_i = ~clk_i;
  end

  // Strobe stays up until the next bus task takes the edge
  task wr(input [7:0] a, input [31:0] d);
    @(posedge clk_i);
    addr_i <= a;
    wdata_i <= d;
    wr_i <= 1'b1;
    rd_i <= 1'b0;
  endtask

  task rd(input [7:0] a, output [31:0] d);
    @(posedge clk_i);
    addr_i <= a;
    wr_i <= 1'b0;
    rd_i <= 1'b1;
    @(posedge clk_i);
    rd_i <= 1'b0;
    #1 d = rdata_o;
  endtask

  task op(input [2:0] m, input [5:0] o, input [127:0] t, input [127:0] e);
    logic [31:0] d;
    logic [7:0]  b;
    int          i;
    wr(8'h00, {29'h0, m});
    wr(8'h0C, {26'h0, o});
    for (i = 0; i < 8; i++) begin
      b = 8'((o[1] && i < 4) ? 4 * (3 - i) : 4 * i);
      d = {b, b + 8'h01, b + 8'h02, b + 8'h03};
      if (o[0] && i < 4) d = {d[7:0], d[15:8], d[23:16], d[31:24]};
      wr(8'h10 + 8'(4 * i), d);
    end
    for (i = 0; i < 4; i++) wr(8'h30 + 8'(4 * i), t[32*i+:32]);
    wr(8'h04, 32'h1);
    // Dropped while busy, result must not show it
    wr(8'h30, 32'hFFFF_FFFF);
    d = 32'h0;
    for (i = 0; i < 100 && d[0] !== 1'b1; i++) rd(8'h08, d);
    `AESC_CHK(d[0], 1'b1)
    for (i = 0; i < 4; i++) begin
      rd(8'h30 + 8'(4 * i), d);
      `AESC_CHK(d, e[32*i+:32])
    end
  endtask

  task s_regs;
    logic [31:0] d;
    int          i;
    wr(8'h10, 32'hA5C3_5A3C);
    rd(8'h10, d);
    `AESC_CHK(d, 32'hA5C3_5A3C)
    wr(8'h30, 32'h1234_5678);
    rd(8'h30, d);
    `AESC_CHK(d, 32'h1234_5678)
    wr(8'h0C, 32'hFFFF_FFFF);
    rd(8'h0C, d);
    `AESC_CHK(d, 32'h0000_003F)
    for (i = 3; i < 8; i += 4) begin
      wr(8'h00, 32'(i));
      rd(8'h00, d);
      `AESC_CHK(d, 32'(i))
      wr(8'h04, 32'h1);
      rd(8'h08, d);
      `AESC_CHK(d, 32'h1)
    end
    rd(8'hFC, d);
    `AESC_CHK(d, 32'h0)
  endtask

  task s_vectors;
    logic [127:0] pt, ct [0:2];
    int           m;
    pt = 128'h00112233_44556677_8899AABB_CCDDEEFF;
    ct[0] = 128'h69C4E0D8_6A7B0430_D8CDB780_70B4C55A;
    ct[1] = 128'hDDA97CA4_864CDFE0_6EAF70A0_EC0D7191;
    ct[2] = 128'h8EA2B7CA_516745BF_EAFC4990_4B496089;
    for (m = 0; m < 3; m++) begin
      op(3'(m), 6'h00, pt, ct[m]);
      op(3'(m + 4), 6'h00, ct[m], pt);
    end
  endtask

  task s_order;
    logic [127:0] pt, ct, ptr, ctr;
    pt = 128'h00112233_44556677_8899AABB_CCDDEEFF;
    ct = 128'h69C4E0D8_6A7B0430_D8CDB780_70B4C55A;
    ptr = 128'hFFEEDDCC_BBAA9988_77665544_33221100;
    ctr = 128'h5AC5B470_80B7CDD8_30047B6A_D8E0C469;
    op(3'h0, 6'h3F, ptr, ctr);
    op(3'h0, 6'h0C, ptr, ct);
    op(3'h0, 6'h30, pt, ctr);
    // Mixed arrangements: key word reverse with in/out byte swap, key byte swap with in/out word order
    op(3'h0, 6'h16, 128'h33221100_77665544_BBAA9988_FFEEDDCC,
       128'hD8E0C469_30047B6A_80B7CDD8_5AC5B470);
    op(3'h0, 6'h29, 128'hCCDDEEFF_8899AABB_44556677_00112233,
       128'h70B4C55A_D8CDB780_6A7B0430_69C4E0D8);
  endtask

  task end_of_test;
    $display("Checks run %0d, mismatches %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  initial begin
    #160000;
    fails++;
    end_of_test;
  end

  initial begin
    fails = 0;
    tests_run = 0;
    resetn_i = 1'b0;
    wr_i = 1'b0;
    rd_i = 1'b0;
    addr_i = 8'h00;
    wdata_i = 32'h0;
    repeat (10) @(posedge clk_i);
    resetn_i <= 1'b1;
    s_regs;
    s_vectors;
    s_order;
    end_of_test;
  end
endmodule // test_aes_block_cipher_core
